// ---- core/arsp_pkg.sv ----
// Shared constants and types of the alarm report serial printer.
// Assumes a single clock domain and plain-port configuration.
package arsp_pkg;

   // ****************************************************************
   // Serial line format and timing
   // ****************************************************************
   localparam int unsigned ARSP_CLK_HZ = 20_000_000;
   localparam int unsigned ARSP_BAUD = 9600;
   localparam int unsigned ARSP_FRAME_BITS = 10;
   localparam int unsigned ARSP_SEC_PER_TICK = 1;
   localparam logic [7:0] ARSP_CR = 8'h0D;
   localparam logic [7:0] ARSP_LF = 8'h0A;
   localparam logic [3:0] ARSP_DIGIT_HI = 4'h3;

   // ****************************************************************
   // Alarm kinds, summary items and per-channel data widths
   // ****************************************************************
   localparam int unsigned ARSP_KINDS = 8;
   localparam int unsigned ARSP_KIND_W = 3;
   localparam int unsigned ARSP_RD_W = 17;
   localparam int unsigned ARSP_SEL_ALARMS = 0;
   localparam int unsigned ARSP_SEL_PRESENT = 1;
   localparam int unsigned ARSP_SEL_MIN = 2;
   localparam int unsigned ARSP_SEL_MAX = 3;
   localparam int unsigned ARSP_SEL_W = 4;
   localparam logic [8*8-1:0] ARSP_KIND_LETTERS = "FI123SLR";
   localparam logic [8*5*8-1:0] ARSP_KIND_NAMES =
      "FAULTINHIBLVL 1LVL 2LVL 3SHTEXLNGEXRATE ";

   // ****************************************************************
   // Report line lengths in characters
   // ****************************************************************
   localparam int unsigned ARSP_LINE_CHARS = 48;
   localparam logic [5:0] ARSP_LEN_HDR = 6'h1D;
   localparam logic [5:0] ARSP_LEN_EVT = 6'h2B;
   localparam logic [5:0] ARSP_LEN_SLOT = 6'h0A;
   localparam logic [5:0] ARSP_LEN_ALM = 6'h10;
   localparam logic [5:0] ARSP_LEN_PRS = 6'h1A;
   localparam logic [5:0] ARSP_LEN_MM = 6'h16;

   // ****************************************************************
   // Line kinds and generator states
   // ****************************************************************
   typedef enum logic [2:0] {
      LK_HDR = 3'b000,
      LK_EVT = 3'b001,
      LK_SLOT = 3'b010,
      LK_ALM = 3'b011,
      LK_PRS = 3'b100,
      LK_MIN = 3'b101,
      LK_MAX = 3'b110
   } arsp_line_t;

   typedef enum logic [1:0] {
      G_IDLE = 2'b00,
      G_CHAR = 2'b01,
      G_CR = 2'b10,
      G_LF = 2'b11
   } arsp_gen_t;

endpackage : arsp_pkg

// ---- core/arsp_printer.sv ----
// Report generator, character FIFO and asynchronous transmitter/receiver.
// Assumes alarm, reading and date inputs come from logic on mclk.
//
// Notes on behaviour
// - Link is asynchronous 9600 baud, eight data bits, one stop, no parity.
// - Every report character is printable ASCII text, apart from the optional CR and LF at line end.
// - Alarm-triggered and interval reporting enable separately or together.
// - Each new alarm prints date, time, alarm type, reading and channel.
// - Eight alarm kinds are watched on every channel of the rack.
// - A per-kind enable mask selects one, some or all kinds.
// - Interval reporting prints a rack summary whenever the period elapses.
// - Summary default gives time, alarms, present, minimum, maximum readings.
// - Summary items are individually selectable.
// - Reporting never holds back or changes the alarm inputs.
// - Summary opens with dd/mm/yy hh:mm and a periodic marker.
// - Channel printed as slot, optional dot and channel; readings ddd.d.
// - Characters go out on transmit data; serial input is received.
// - Terminal-ready output is driven toward the far end.
// - Hardware handshake only; received bytes are never flow control.
// - Carriage return at line end is optional.
// - Line feed at line end is optional.
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Small FIFO with valid/ready on both sides
// ********************************************************************
module arsp_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Fill side.
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Drain side.
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } arsp_fifo_st_t;

   arsp_fifo_st_t s_q;
   arsp_fifo_st_t s_d;
   logic push;
   logic pop;

   // Next state: write on accepted push, advance on accepted pop.
   always_comb begin
      s_d = s_q;
      in_ready = (s_q.cnt != (AW+1)'(DEPTH));
      out_valid = (s_q.cnt != '0);
      out_data = s_q.mem[s_q.rp];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   // State register.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : arsp_fifo

// ********************************************************************
// Top: alarm scanner, report generator and serial port
// ********************************************************************
module arsp_printer #(
   parameter int unsigned N_CH = 16,
   parameter int unsigned CLK_HZ = arsp_pkg::ARSP_CLK_HZ,
   parameter int unsigned CYC_PER_SEC = CLK_HZ,
   parameter int unsigned EV_DEPTH = 4,
   parameter int unsigned CH_DEPTH = 4
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Serial pins.
   output logic txd_q,
   input wire logic rxd,
   output logic dtr_q,
   input wire logic dsr,
   // Received bytes, passed on untouched.
   output logic [7:0] rx_data_q,
   output logic rx_valid_q,
   // Configuration.
   input wire logic evt_en,
   input wire logic per_en,
   input wire logic [arsp_pkg::ARSP_KINDS-1:0] kind_en,
   input wire logic [arsp_pkg::ARSP_SEL_W-1:0] sum_sel,
   input wire logic cr_en,
   input wire logic lf_en,
   input wire logic [15:0] per_sec,
   // Date and time in BCD.
   input wire logic [7:0] day_bcd,
   input wire logic [7:0] mon_bcd,
   input wire logic [7:0] yr_bcd,
   input wire logic [7:0] hr_bcd,
   input wire logic [7:0] min_bcd,
   // Per-channel rack data, channel 0 in the low bits.
   input wire logic [N_CH*arsp_pkg::ARSP_KINDS-1:0] alarm_state,
   input wire logic [N_CH*8-1:0] slot_bcd,
   input wire logic [N_CH*4-1:0] sub_ch,
   input wire logic [N_CH*arsp_pkg::ARSP_RD_W-1:0] rd_now,
   input wire logic [N_CH*arsp_pkg::ARSP_RD_W-1:0] rd_min,
   input wire logic [N_CH*arsp_pkg::ARSP_RD_W-1:0] rd_max,
   // Report activity.
   output logic busy_q
);
   import arsp_pkg::*;

   localparam int unsigned CW = $clog2(N_CH);
   localparam int unsigned SCW = CW + ARSP_KIND_W;
   localparam int unsigned NB = N_CH * ARSP_KINDS;
   localparam int unsigned BAUD_DIV = (CLK_HZ + ARSP_BAUD / 2) / ARSP_BAUD;
   localparam int unsigned BDW = $clog2(BAUD_DIV + 1);
   localparam int unsigned PW = $clog2(CYC_PER_SEC * ARSP_SEC_PER_TICK + 1);
   localparam logic [BDW-1:0] BIT_LAST = BDW'(BAUD_DIV - 1);
   localparam logic [BDW-1:0] BIT_HALF = BDW'(BAUD_DIV / 2);
   localparam logic [PW-1:0] SEC_LAST =
      PW'(CYC_PER_SEC * ARSP_SEC_PER_TICK - 1);
   localparam logic [CW-1:0] CH_LAST = CW'(N_CH - 1);

   typedef struct packed {
      logic [1:0] rxd_s;
      logic [1:0] dsr_s;
      logic dtr;
      logic txd;
      logic tx_busy;
      logic [BDW-1:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic rx_busy;
      logic [BDW-1:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic [7:0] rx_data;
      logic rx_valid;
      logic [SCW-1:0] ptr;
      logic [NB-1:0] seen;
      logic [PW-1:0] pre;
      logic [15:0] sec;
      logic per_pend;
      arsp_gen_t gs;
      arsp_line_t lk;
      logic [CW-1:0] ch;
      logic [2:0] kind;
      logic [5:0] pos;
      logic busy;
   } arsp_st_t;

   arsp_st_t s_q;
   arsp_st_t s_d;
   logic ef_push;
   logic ef_in_ready;
   logic ef_out_valid;
   logic [SCW-1:0] ef_out_data;
   logic ef_pop;
   logic cf_push;
   logic [7:0] cf_data;
   logic cf_in_ready;
   logic cf_out_valid;
   logic [7:0] cf_out_data;
   logic cf_pop;

   // One ASCII digit from a BCD nibble.
   function automatic logic [7:0] dig(input logic [3:0] n);
      return {ARSP_DIGIT_HI, n};
   endfunction : dig

   // Reading as sign or space, three digits, point and one decimal.
   function automatic logic [47:0] fmt_rd(input logic [16:0] v);
      logic [7:0] sg;
      sg = v[16] ? "-" : " ";
      return {sg, dig(v[15:12]), dig(v[11:8]), dig(v[7:4]), ".",
              dig(v[3:0])};
   endfunction : fmt_rd

   // ****************************************************************
   // Queues: alarm events and outgoing characters
   // ****************************************************************
   arsp_fifo #(.W(SCW), .DEPTH(EV_DEPTH)) u_evq (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(ef_push),
      .in_data(s_q.ptr),
      .in_ready(ef_in_ready),
      .out_valid(ef_out_valid),
      .out_data(ef_out_data),
      .out_ready(ef_pop)
   );

   arsp_fifo #(.W(8), .DEPTH(CH_DEPTH)) u_chq (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(cf_push),
      .in_data(cf_data),
      .in_ready(cf_in_ready),
      .out_valid(cf_out_valid),
      .out_data(cf_out_data),
      .out_ready(cf_pop)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [8*14-1:0] date;
      logic [8*4-1:0] slot;
      logic [7:0] sl;
      logic [3:0] sb;
      logic [16:0] rv;
      logic [8*ARSP_KINDS-1:0] flags;
      logic [8*ARSP_LINE_CHARS-1:0] lnbuf;
      logic [5:0] len;
      logic found;
      logic cur;
      s_d = s_q;
      date = '0;
      slot = '0;
      sl = '0;
      sb = '0;
      rv = '0;
      flags = '0;
      lnbuf = '0;
      len = ARSP_LEN_SLOT;
      found = 1'b0;
      cur = 1'b0;
      ef_push = 1'b0;
      ef_pop = 1'b0;
      cf_push = 1'b0;
      cf_pop = 1'b0;
      s_d.rx_valid = 1'b0;

      // Pin synchronisers; only the second stage is used below.
      s_d.rxd_s = {s_q.rxd_s[0], rxd};
      s_d.dsr_s = {s_q.dsr_s[0], dsr};
      s_d.dtr = 1'b1;

      // Alarm scan: one bit a cycle, a rising alarm of an enabled kind is queued while evt_en is high.
      // The scan waits on a full queue so no activation is lost.
      cur = alarm_state[s_q.ptr];
      if (!cur) begin
         s_d.seen[s_q.ptr] = 1'b0;
         s_d.ptr = s_q.ptr + 1'b1;
      end else if (s_q.seen[s_q.ptr]) begin
         s_d.ptr = s_q.ptr + 1'b1;
      end else if (evt_en && kind_en[s_q.ptr[2:0]]) begin
         ef_push = 1'b1;
         if (ef_in_ready) begin
            s_d.seen[s_q.ptr] = 1'b1;
            s_d.ptr = s_q.ptr + 1'b1;
         end
      end else begin
         s_d.seen[s_q.ptr] = 1'b1;
         s_d.ptr = s_q.ptr + 1'b1;
      end

      // Text of the current line, right-justified in lnbuf.
      date = {dig(day_bcd[7:4]), dig(day_bcd[3:0]), "/",
              dig(mon_bcd[7:4]), dig(mon_bcd[3:0]), "/",
              dig(yr_bcd[7:4]), dig(yr_bcd[3:0]), " ",
              dig(hr_bcd[7:4]), dig(hr_bcd[3:0]), ":",
              dig(min_bcd[7:4]), dig(min_bcd[3:0])};
      sl = slot_bcd[int'(s_q.ch)*8 +: 8];
      sb = sub_ch[int'(s_q.ch)*4 +: 4];
      slot = (sb != 4'h0) ? {dig(sl[7:4]), dig(sl[3:0]), ".", dig(sb)}
                          : {dig(sl[7:4]), dig(sl[3:0]), "  "};
      rv = rd_now[int'(s_q.ch)*ARSP_RD_W +: ARSP_RD_W];
      if (s_q.lk == LK_MIN) begin
         rv = rd_min[int'(s_q.ch)*ARSP_RD_W +: ARSP_RD_W];
      end else if (s_q.lk == LK_MAX) begin
         rv = rd_max[int'(s_q.ch)*ARSP_RD_W +: ARSP_RD_W];
      end
      for (int k = 0; k < ARSP_KINDS; k++) begin
         flags[(ARSP_KINDS-1-k)*8 +: 8] =
            alarm_state[int'(s_q.ch)*ARSP_KINDS + k] ?
            ARSP_KIND_LETTERS[(ARSP_KINDS-1-k)*8 +: 8] : "-";
      end
      unique case (s_q.lk)
         LK_HDR: begin
            lnbuf = (8*ARSP_LINE_CHARS)'({date, " ** Periodic **"});
            len = ARSP_LEN_HDR;
         end
         LK_EVT: begin
            lnbuf = (8*ARSP_LINE_CHARS)'({date, " ",
               ARSP_KIND_NAMES[(ARSP_KINDS-1-int'(s_q.kind))*40 +: 40],
               " Slot: ", slot, " ", fmt_rd(rv), " %fsd"});
            len = ARSP_LEN_EVT;
         end
         LK_SLOT: begin
            lnbuf = (8*ARSP_LINE_CHARS)'({"Slot: ", slot});
            len = ARSP_LEN_SLOT;
         end
         LK_ALM: begin
            lnbuf = (8*ARSP_LINE_CHARS)'(
               (flags == {ARSP_KINDS{"-"}}) ? {"Alarms: none    "}
                                            : {"Alarms: ", flags});
            len = ARSP_LEN_ALM;
         end
         LK_PRS: begin
            lnbuf = (8*ARSP_LINE_CHARS)'({"Present signal:", fmt_rd(rv),
                                          " %fsd"});
            len = ARSP_LEN_PRS;
         end
         LK_MIN: begin
            lnbuf = (8*ARSP_LINE_CHARS)'({"Min signal:", fmt_rd(rv),
                                          " %fsd"});
            len = ARSP_LEN_MM;
         end
         LK_MAX: begin
            lnbuf = (8*ARSP_LINE_CHARS)'({"Max signal:", fmt_rd(rv),
                                          " %fsd"});
            len = ARSP_LEN_MM;
         end
         default: begin
            len = ARSP_LEN_SLOT;
         end
      endcase
      cf_data = lnbuf[(int'(len) - 1 - int'(s_q.pos))*8 +: 8];

      // Report generator; it stalls on a full character queue only.
      unique case (s_q.gs)
         G_IDLE: begin
            s_d.pos = '0;
            if (ef_out_valid) begin
               ef_pop = 1'b1;
               s_d.ch = ef_out_data[SCW-1:ARSP_KIND_W];
               s_d.kind = ef_out_data[ARSP_KIND_W-1:0];
               s_d.lk = LK_EVT;
               s_d.gs = G_CHAR;
            end else if (s_q.per_pend) begin
               s_d.per_pend = 1'b0;
               s_d.lk = LK_HDR;
               s_d.gs = G_CHAR;
            end
         end
         G_CHAR: begin
            cf_push = 1'b1;
            if (cf_in_ready) begin
               if (s_q.pos == len - 6'h01) begin
                  s_d.pos = '0;
                  s_d.gs = G_CR;
               end else begin
                  s_d.pos = s_q.pos + 6'h01;
               end
            end
         end
         G_CR: begin
            cf_data = ARSP_CR;
            cf_push = cr_en;
            if (cf_in_ready || !cr_en) begin
               s_d.gs = G_LF;
            end
         end
         G_LF: begin
            cf_data = ARSP_LF;
            cf_push = lf_en;
            if (cf_in_ready || !lf_en) begin
               s_d.gs = G_CHAR;
               if (s_q.lk == LK_EVT) begin
                  s_d.gs = G_IDLE;
               end else if (s_q.lk == LK_HDR) begin
                  s_d.lk = LK_SLOT;
                  s_d.ch = '0;
               end else begin
                  // Next selected item of this channel, else next channel.
                  for (int i = 0; i < ARSP_SEL_W; i++) begin
                     if (!found && (i + 3 > int'(s_q.lk)) && sum_sel[i]) begin
                        found = 1'b1;
                        s_d.lk = arsp_line_t'(3'(i + 3));
                     end
                  end
                  if (!found) begin
                     s_d.lk = LK_SLOT;
                     if (s_q.ch == CH_LAST) begin
                        s_d.gs = G_IDLE;
                     end else begin
                        s_d.ch = s_q.ch + 1'b1;
                     end
                  end
               end
            end
         end
         default: begin
            s_d.gs = G_IDLE;
         end
      endcase
      // Activity flag kept in its own flop so the output is registered.
      s_d.busy = (s_d.gs != G_IDLE);

      // Interval timer; a new period sets the pending flag last.
      if (!per_en) begin
         s_d.pre = '0;
         s_d.sec = '0;
      end else if (s_q.pre == SEC_LAST) begin
         s_d.pre = '0;
         if (s_q.sec + 16'h0001 >= per_sec) begin
            s_d.sec = '0;
            if (per_sec != 16'h0000) begin
               s_d.per_pend = 1'b1;
            end
         end else begin
            s_d.sec = s_q.sec + 16'h0001;
         end
      end else begin
         s_d.pre = s_q.pre + 1'b1;
      end

      // Transmitter: start only with set-ready high, finish regardless.
      if (!s_q.tx_busy) begin
         if (cf_out_valid && s_q.dsr_s[1]) begin
            cf_pop = 1'b1;
            s_d.tx_sh = {1'b1, cf_out_data, 1'b0};
            s_d.tx_busy = 1'b1;
            s_d.tx_cnt = '0;
            s_d.tx_bit = '0;
         end
      end else if (s_q.tx_cnt == BIT_LAST) begin
         s_d.tx_cnt = '0;
         s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
         s_d.tx_bit = s_q.tx_bit + 4'h1;
         if (s_q.tx_bit == 4'(ARSP_FRAME_BITS - 1)) begin
            s_d.tx_busy = 1'b0;
         end
      end else begin
         s_d.tx_cnt = s_q.tx_cnt + 1'b1;
      end
      s_d.txd = s_d.tx_sh[0];

      // Receiver: sample mid-bit, hand bytes out without interpretation.
      if (!s_q.rx_busy) begin
         if (!s_q.rxd_s[1]) begin
            s_d.rx_busy = 1'b1;
            s_d.rx_cnt = BIT_HALF;
            s_d.rx_bit = '0;
         end
      end else if (s_q.rx_cnt != '0) begin
         s_d.rx_cnt = s_q.rx_cnt - 1'b1;
      end else begin
         s_d.rx_cnt = BIT_LAST;
         s_d.rx_bit = s_q.rx_bit + 4'h1;
         if (s_q.rx_bit == 4'h0) begin
            s_d.rx_busy = !s_q.rxd_s[1];
         end else if (s_q.rx_bit != 4'(ARSP_FRAME_BITS - 1)) begin
            s_d.rx_sh = {s_q.rxd_s[1], s_q.rx_sh[7:1]};
         end else begin
            s_d.rx_busy = 1'b0;
            if (s_q.rxd_s[1]) begin
               s_d.rx_data = s_q.rx_sh;
               s_d.rx_valid = 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // State register and outputs
   // ****************************************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.rxd_s <= 2'h3;
         s_q.txd <= 1'b1;
         s_q.tx_sh <= 10'h3FF;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state flops; alarms are only read.
   assign txd_q = s_q.txd;
   assign dtr_q = s_q.dtr;
   assign rx_data_q = s_q.rx_data;
   assign rx_valid_q = s_q.rx_valid;
   assign busy_q = s_q.busy;
endmodule : arsp_printer

`default_nettype wire

// ---- core/arsp_unused_placeholder_removed.sv ----
// Intentionally empty design unit list; all logic sits in arsp_printer.sv.
// Assumes nothing of its surroundings.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- tb/arsp_printer_bench.sv ----
// Self-checking bench for the alarm report serial printer.
// Assumes the printer model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench top
// ********
module arsp_printer_bench;
   import arsp_pkg::*;
   localparam int N = 2;
   localparam string D = "30/01/97 13:00 ";
   logic mclk, rstn, txd_q, rxd, dtr_q, dsr, rx_valid_q, busy_q, hold;
   logic evt_en, per_en, cr_en, lf_en;
   logic [7:0] rx_data_q, rx_seen, kind_en;
   logic [3:0] sum_sel;
   logic [15:0] per_sec;
   logic [39:0] dt;
   logic [N*8-1:0] alarm_state, slot_bcd;
   logic [N*4-1:0] sub_ch;
   logic [N*ARSP_RD_W-1:0] rd_now;
   int miscompares, samples_checked, n;
   arsp_printer #(.N_CH(N), .CLK_HZ(96000), .CYC_PER_SEC(20)) i_arsp_printer (
      .mclk(mclk), .rstn(rstn), .txd_q(txd_q), .rxd(rxd), .dtr_q(dtr_q),
      .dsr(dsr), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q),
      .evt_en(evt_en), .per_en(per_en), .kind_en(kind_en),
      .sum_sel(sum_sel), .cr_en(cr_en), .lf_en(lf_en), .per_sec(per_sec),
      .day_bcd(dt[39:32]), .mon_bcd(dt[31:24]), .yr_bcd(dt[23:16]),
      .hr_bcd(dt[15:8]), .min_bcd(dt[7:0]), .alarm_state(alarm_state),
      .slot_bcd(slot_bcd), .sub_ch(sub_ch), .rd_now(rd_now),
      .rd_min({rd_now[16:0], rd_now[33:17]}),
      .rd_max(rd_now ^ 34'h200010000),
      .busy_q(busy_q));
   arsp_term #(.BIT(10)) i_arsp_term (.mclk(mclk), .txd(txd_q), .dtr(dtr_q),
      .rxd(rxd), .dsr(dsr), .hold(hold));
   // Makes the 20 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Keeps the byte that the port last flagged as received.
   always @(posedge mclk) begin
      if (rx_valid_q === 1'b1) begin
         rx_seen <= rx_data_q;
      end
   end
   // Compares one value and counts the outcome.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   // Waits for each character of s at the printer and compares it.
   task automatic expect_str(input string s);
      int w;
      for (int i = 0; i < s.len(); i++) begin
         w = 0;
         while (i_arsp_term.got.size() == 0 && w < 3000) begin
            @(posedge mclk);
            w++;
         end
         check(i_arsp_term.got.size() ? i_arsp_term.got.pop_front() : 8'h00,
            s[i]);
      end
   endtask : expect_str
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // Cuts a hung run short.
   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      results();
   end
   // Main sequence of scenarios.
   initial begin
      miscompares = 0;
      samples_checked = 0;
      dt = 40'h3001971300;
      rstn = 1'b0;
      hold = 1'b0;
      evt_en = 1'b0;
      per_en = 1'b0;
      cr_en = 1'b1;
      lf_en = 1'b1;
      kind_en = 8'h0C;
      sum_sel = 4'h0;
      per_sec = 16'h0001;
      alarm_state = '0;
      slot_bcd = 16'h1209;
      sub_ch = 8'h01;
      rd_now = {1'b1, 16'h0045, 1'b0, 16'h0020};
      repeat (2) @(posedge mclk);
      check({6'h00, txd_q, dtr_q}, 8'h02);
      rstn <= 1'b1;
      @(posedge mclk);
      evt_en <= 1'b1;
      i_arsp_term.send(8'h13);
      repeat (20) @(posedge mclk);
      check(rx_seen, 8'h13);
      alarm_state <= 16'h000C;
      expect_str({D, "LVL 1 Slot: 09.1  002.0 %fsd\015\012"});
      expect_str(D);
      hold <= 1'b1;
      repeat (300) @(posedge mclk);
      check(8'(i_arsp_term.got.size() <= 1), 8'h01);
      hold <= 1'b0;
      expect_str("LVL 2 Slot: 09.1  002.0 %fsd\015\012");
      alarm_state <= 16'h000D;
      repeat (200) @(posedge mclk);
      check({7'h00, busy_q}, 8'h00);
      check(8'(i_arsp_term.got.size()), 8'h00);
      cr_en <= 1'b0;
      lf_en <= 1'b0;
      kind_en <= 8'h02;
      alarm_state <= 16'h020D;
      expect_str({D, "INHIB Slot: 12   -004.5 %fsd"});
      per_en <= 1'b1;
      n = 0;
      while (busy_q !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      per_en <= 1'b0;
      expect_str({D, "** Periodic **"});
      expect_str("Slot: 09.1Slot: 12  ");
      // Full summary on a new date; min and max differ from present.
      sum_sel <= 4'hF;
      dt <= 40'h0512031945;
      per_en <= 1'b1;
      n = 0;
      while (busy_q !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      per_en <= 1'b0;
      expect_str("05/12/03 19:45 ** Periodic **");
      expect_str(string'({"Slot: 09.1Alarms: F-12----",
         "Present signal: 002.0 %fsdMin signal:-004.5 %fsd",
         "Max signal:-002.0 %fsdSlot: 12  Alarms: -I------",
         "Present signal:-004.5 %fsdMin signal: 002.0 %fsd",
         "Max signal: 004.5 %fsd"}));
      check({7'h00, i_arsp_term.bad}, 8'h00);
      results();
   end
endmodule : arsp_printer_bench
`default_nettype wire

// ---- tb/arsp_printer_chk.sv ----
// Checker for the serial pins and status outputs of the printer port.
// Assumes one clock, mclk, and rstn as asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module arsp_chk #(
   parameter int unsigned CLK_HZ = 96000
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Watched ports.
   input wire logic txd_q,
   input wire logic dtr_q,
   input wire logic dsr,
   input wire logic [7:0] rx_data_q,
   input wire logic rx_valid_q,
   input wire logic evt_en,
   input wire logic per_en,
   input wire logic busy_q
);
   localparam int BIT = (CLK_HZ + 4800) / 9600;
   int fc_q;
   int low_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Tracks the position inside a frame and the length of a low run.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fc_q <= 0;
         low_q <= 0;
      end else begin
         low_q <= txd_q ? 0 : low_q + 1;
         if (fc_q != 0) begin
            fc_q <= (fc_q == 10 * BIT - 1) ? 0 : fc_q + 1;
         end else if (!txd_q) begin
            fc_q <= 1;
         end
      end
   end
   a_term_ready: assert property (rstn |=> dtr_q)
      else $error("terminal ready low after reset");
   a_start_low: assert property (fc_q inside {[1:BIT-1]} |-> !txd_q)
      else $error("start bit too short");
   a_stop_high: assert property (fc_q >= 9 * BIT |-> txd_q)
      else $error("stop bit not high");
   a_bit_length: assert property ($rose(txd_q) |-> low_q % BIT == 0)
      else $error("low run not whole bit times");
   a_dsr_hold: assert property (!dsr [*6] |-> txd_q || fc_q != 0)
      else $error("frame started while set-ready low");
   a_rx_pulse: assert property (rx_valid_q |=> !rx_valid_q)
      else $error("receive flag longer than one cycle");
   a_rx_hold: assert property ($changed(rx_data_q) |-> rx_valid_q)
      else $error("receive byte changed without flag");
   a_quiet_off: assert property (!evt_en && !per_en && !busy_q |=> !busy_q)
      else $error("report started with both modes off");
   c_frame: cover property (fc_q == 10 * BIT - 1);
   c_rx: cover property (rx_valid_q);
   c_stall: cover property (!dsr && fc_q != 0);
endmodule : arsp_chk

bind arsp_printer arsp_chk #(.CLK_HZ(CLK_HZ)) i_arsp_chk (
   .mclk, .rstn, .txd_q, .dtr_q, .dsr, .rx_data_q, .rx_valid_q,
   .evt_en, .per_en, .busy_q
);
`default_nettype wire

// ---- tb/arsp_term.sv ----
// Serial printer model: takes frames from the port and can send bytes.
// Assumes a bit time of BIT mclk cycles and a high idle line.
`timescale 1ns/1ps
`default_nettype none
// ********
// Printer model
// ********
module arsp_term #(
   parameter int BIT = 10
) (
   // Clock.
   input wire logic mclk,
   // Serial pins seen from the printer side.
   input wire logic txd,
   input wire logic dtr,
   output logic rxd,
   output logic dsr,
   // Stall request from the bench.
   input wire logic hold
);
   logic [7:0] got[$];
   logic [7:0] sh;
   logic bad;
   // Ready only while the port is ready and no stall is asked for.
   assign dsr = dtr && !hold;
   // Samples each frame mid-bit, low bit first, and checks the stop bit.
   initial begin
      bad = 1'b0;
      rxd = 1'b1;
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge mclk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk);
            sh = {txd, sh[7:1]};
         end
         repeat (BIT) @(posedge mclk);
         if (txd !== 1'b1) begin
            bad = 1'b1;
         end
         got.push_back(sh);
      end
   end
   // Sends one byte toward the port: start, eight data bits, stop.
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk);
         rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
         repeat (BIT - 1) @(posedge mclk);
      end
   endtask : send
endmodule : arsp_term
`default_nettype wire
